/* hdl/shunt_adc_sinc3_decimator_cal.sv */
// Shunt converter digital back end: modulator clocking, sinc3 decimation,
// offset and gain trim, rounding, clipping and hand-off to frame logic.
// Assumes config inputs come from logic on clk; the modulator bit is a pin.
//
// Behaviour
// - Modulator rate is main clock halved
// - One single-bit sample per modulator period
// - Sinc3 FIR decimates by OSR
// - Three-bit ratio field, 64 to 8192
// - Eight power-of-two ratios supported
// - Data rate is modulator rate over OSR
// - Zeros at multiples of output rate
// - Subtract offset, then multiply by gain
// - Round to 24 bits, saturate both ends
// - Offset is 24-bit, split upper/lower
// - Offset LSB is one code, positive lowers
// - Gain factor is one plus signed field/65536
// - Result fills frame unless register read
// - Two's-complement output codes
// - Clip at 800000h and 7FFFFFh
// - Two-bit amplifier gain 4 to 32
`timescale 1ns/10ps
`include "shunt_adc_cfg.svh"

module shunt_adc_sinc3_decimator_cal (
  input  wire logic        clk,                        // Main clock, 125 MHz
  input  wire logic        arst_n,                     // Async reset, active low
  input  wire logic        mod_bit_in,                 // Modulator bit pin
  input  wire logic [2:0]  shunt_decimation_ratio_sel, // Ratio code
  input  wire logic [7:0]  shunt_offset_trim_upper,    // Offset bits 23:16
  input  wire logic [15:0] shunt_offset_trim_lower,    // Offset bits 15:0
  input  wire logic [15:0] shunt_gain_trim,            // Gain trim field
  input  wire logic [1:0]  shunt_amp_gain_sel,         // Amplifier gain code
  input  wire logic [1:0]  shunt_input_select,         // Input mux code
  input  wire logic        frame_start,                // Frame load pulse
  input  wire logic        reg_read_frame,             // Frame carries reg data
  input  wire logic [23:0] reg_read_data,              // Register read data
  output logic             mod_clk_out,                // Modulator clock
  output logic [1:0]       amp_gain_ctrl,              // Gain to amplifier
  output logic [1:0]       input_select_ctrl,          // Code to input mux
  output logic [23:0]      result_code,                // Calibrated result
  output logic             result_valid,               // Result strobe
  output logic [23:0]      frame_word                  // Word for the frame
);

  // ============================================================
  // Ratio decode, used by the filter and by the normaliser
  function automatic logic [3:0] osr_log2_of(input logic [2:0] sel);
    osr_log2_of = `SHUNT_LOG2_MIN + {1'b0, sel};
  endfunction : osr_log2_of

  logic                         bit_meta_ff;
  logic                         bit_sync_ff;
  logic                         sample_en;
  logic [2:0]                   ratio_ff;
  logic                         restart_ff;
  logic [1:0]                   drop_ff;
  logic [`SHUNT_CIC_W-1:0]      cic_data;
  logic                         cic_valid;
  logic [3:0]                   log2_cur;
  logic [5:0]                   cube_log2;
  logic signed [`SHUNT_NORM_W-1:0] centered;
  logic signed [`SHUNT_NORM_W-1:0] norm;
  logic signed [`SHUNT_TRIM_W-1:0] offset_wide;
  logic signed [`SHUNT_TRIM_W-1:0] trim_ff;
  logic signed [17:0]           gain_factor;
  logic signed [`SHUNT_PROD_W-1:0] prod_ff;
  logic signed [`SHUNT_PROD_W-1:0] rounded;
  logic signed [`SHUNT_WIDE_W-1:0] code_wide;
  shunt_adc_pkg::cal_state_t    state_ff;
  shunt_adc_pkg::code_t         clipped;
  logic [7:0]                   gap_ff;
  logic                         seen_ff;

  // ============================================================
  // Modulator clock and sample enable
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mod_clk_out <= 1'b0;
    end else begin
      mod_clk_out <= !mod_clk_out;
    end
  end

  // Sample on the cycle the modulator clock is high, once per period
  assign sample_en = mod_clk_out;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_meta_ff <= 1'b0;
      bit_sync_ff <= 1'b0;
    end else begin
      bit_meta_ff <= mod_bit_in;
      bit_sync_ff <= bit_meta_ff;
    end
  end

  // ============================================================
  // Analog front-end controls
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      amp_gain_ctrl     <= '0;
      input_select_ctrl <= '0;
    end else begin
      amp_gain_ctrl     <= shunt_amp_gain_sel;
      input_select_ctrl <= shunt_input_select;
    end
  end

  // ============================================================
  // Ratio change restarts the filter; a filter output valid in the restart cycle is normalised at the new ratio
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ratio_ff   <= '0;
      restart_ff <= 1'b0;
    end else begin
      restart_ff <= shunt_decimation_ratio_sel != ratio_ff;
      ratio_ff   <= shunt_decimation_ratio_sel;
    end
  end

  // Sinc3 needs three output periods to settle; drop the first two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drop_ff <= `SHUNT_SETTLE_DROP;
    end else if (restart_ff) begin
      drop_ff <= `SHUNT_SETTLE_DROP;
    end else if (cic_valid && drop_ff != 2'h0) begin
      drop_ff <= drop_ff - 2'h1;
    end
  end

  assign log2_cur = osr_log2_of(ratio_ff);

  shunt_sinc3_cic #(
    .W  (`SHUNT_CIC_W),
    .CW (`SHUNT_CNT_W)
  ) u_cic (
    .clk        (clk),
    .arst_n     (arst_n),
    .sample_en  (sample_en),
    .bit_in     (bit_sync_ff),
    .osr_log2   (log2_cur),
    .restart    (restart_ff),
    .data       (cic_data),
    .data_valid (cic_valid)
  );

  // ============================================================
  // Normalise: centre the ones density and scale so full scale is
  // 2^23 codes with FRAC_W fraction bits kept for rounding
  assign cube_log2 = 6'(3 * log2_cur);
  assign centered  = $signed({8'h00, cic_data})
                   - (`SHUNT_NORM_W'(1) <<< (cube_log2 - 6'h1));
  assign norm      = centered <<< (`SHUNT_NORM_TOP - cube_log2);

  // Positive offset lowers the value by that many codes before the gain multiply
  assign offset_wide = `SHUNT_TRIM_W'($signed({shunt_offset_trim_upper,
                       shunt_offset_trim_lower})) <<< `SHUNT_FRAC_W;
  assign gain_factor = `SHUNT_GAIN_ONE + 18'($signed(shunt_gain_trim));

  // ============================================================
  // Calibration pipeline: offset, gain, round and clip
  assign rounded   = prod_ff + `SHUNT_ROUND_HALF;
  assign code_wide = `SHUNT_WIDE_W'(rounded >>> `SHUNT_SCALE_SHIFT);

  always_comb begin
    if (code_wide > `SHUNT_POS_WIDE) begin
      clipped = `SHUNT_POS_FS;
    end else if (code_wide < `SHUNT_NEG_WIDE) begin
      clipped = `SHUNT_NEG_FS;
    end else begin
      clipped = code_wide[23:0];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= shunt_adc_pkg::CAL_IDLE;
    end else begin
      unique case (state_ff)
        shunt_adc_pkg::CAL_IDLE: begin
          if (cic_valid && drop_ff == 2'h0) begin
            state_ff <= shunt_adc_pkg::CAL_MULT;
          end
        end
        shunt_adc_pkg::CAL_MULT: begin
          state_ff <= shunt_adc_pkg::CAL_ROUND;
        end
        shunt_adc_pkg::CAL_ROUND: begin
          state_ff <= shunt_adc_pkg::CAL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trim_ff <= '0;
      prod_ff <= '0;
    end else begin
      if (cic_valid) begin
        trim_ff <= `SHUNT_TRIM_W'(norm) - offset_wide;
      end
      if (state_ff == shunt_adc_pkg::CAL_MULT) begin
        prod_ff <= `SHUNT_PROD_W'(trim_ff) * `SHUNT_PROD_W'(gain_factor);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_code  <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= state_ff == shunt_adc_pkg::CAL_ROUND;
      if (state_ff == shunt_adc_pkg::CAL_ROUND) begin
        result_code <= clipped;
      end
    end
  end

  // ============================================================
  // Frame word: latest result unless the frame returns register data
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      frame_word <= '0;
    end else if (frame_start) begin
      frame_word <= reg_read_frame ? reg_read_data : result_code;
    end
  end

  // ============================================================
  // Checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_ff  <= '0;
      seen_ff <= 1'b0;
    end else if (result_valid) begin
      gap_ff  <= '0;
      seen_ff <= 1'b1;
    end else if (gap_ff != `SHUNT_GAP_MAX) begin
      gap_ff <= gap_ff + 8'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence s_cic_kept;
    cic_valid && drop_ff == 2'h0;
  endsequence

  sequence s_pipe_walk;
    state_ff == shunt_adc_pkg::CAL_MULT ##1 state_ff == shunt_adc_pkg::CAL_ROUND
      ##1 result_valid;
  endsequence

  a_mod_rate_half: assert property (sample_en |=> !sample_en ##1 sample_en)
    else $error("modulator enable not at half main clock");

  a_bit_per_period: assert property (sample_en |-> !$past(sample_en))
    else $error("two samples in one modulator period");

  a_result_pipeline: assert property (s_cic_kept |=> s_pipe_walk)
    else $error("result did not follow filter output in three cycles");

  a_valid_single: assert property (result_valid |=> !result_valid)
    else $error("result strobe longer than one cycle");

  a_result_spacing: assert property (result_valid && seen_ff |-> gap_ff >= `SHUNT_MIN_GAP)
    else $error("results closer than the smallest ratio allows");

  a_ratio_decode: assert property (u_cic.osr_full == (`SHUNT_OSR_MIN << ratio_ff))
    else $error("ratio code maps to wrong decimation");

  a_clip_pos: assert property (state_ff == shunt_adc_pkg::CAL_ROUND
                               && code_wide > `SHUNT_POS_WIDE
                               |=> result_code == `SHUNT_POS_FS)
    else $error("positive overrange not clipped");

  a_clip_neg: assert property (state_ff == shunt_adc_pkg::CAL_ROUND
                               && code_wide < `SHUNT_NEG_WIDE
                               |=> result_code == `SHUNT_NEG_FS)
    else $error("negative overrange not clipped");

  a_frame_select: assert property (frame_start && !reg_read_frame
                                   |=> frame_word == $past(result_code))
    else $error("frame word is not the latest result");

  a_amp_gain_follow: assert property (##1 amp_gain_ctrl == $past(shunt_amp_gain_sel))
    else $error("amplifier gain not forwarded");

endmodule : shunt_adc_sinc3_decimator_cal

/* hdl/shunt_adc_cfg.svh */
// Constants for the shunt converter digital back end: widths, codes, counts.
// Assumes inclusion by bare name from files under hdl/.
`ifndef SHUNT_ADC_CFG_SVH
`define SHUNT_ADC_CFG_SVH

// ============================================================
// Data path widths
`define SHUNT_CODE_W      24
`define SHUNT_CIC_W       40
`define SHUNT_CNT_W       13
`define SHUNT_NORM_W      48
`define SHUNT_TRIM_W      49
`define SHUNT_PROD_W      67
`define SHUNT_WIDE_W      35

// ============================================================
// Ratio and scaling
`define SHUNT_MOD_DIV     2
`define SHUNT_LOG2_MIN    4'h6
`define SHUNT_OSR_MIN     14'h0040
`define SHUNT_NORM_TOP    6'h28
`define SHUNT_FRAC_W      16
`define SHUNT_GAIN_ONE    18'sh10000
`define SHUNT_ROUND_HALF  67'sh80000000
`define SHUNT_SCALE_SHIFT 32

// ============================================================
// Output codes and sequencing
`define SHUNT_POS_FS      24'h7FFFFF
`define SHUNT_NEG_FS      24'h800000
`define SHUNT_POS_WIDE    35'sh7FFFFF
`define SHUNT_NEG_WIDE    (-35'sh800000)
`define SHUNT_SETTLE_DROP 2'h2
`define SHUNT_MIN_GAP     8'h7F
`define SHUNT_GAP_MAX     8'hFF

`endif

/* hdl/shunt_adc_pkg.sv */
// Types shared by the shunt converter back end.
// Assumes no other package.
package shunt_adc_pkg;

  // ============================================================
  // Calibration pipeline
  typedef enum logic [1:0] {CAL_IDLE, CAL_MULT, CAL_ROUND} cal_state_t;

  typedef logic [23:0] code_t;

endpackage : shunt_adc_pkg

/* hdl/shunt_sinc3_cic.sv */
// Third-order sinc decimator: three integrators at the modulator rate,
// three combs at the output rate. Ratio is a power of two given as log2.
// Assumes sample_en pulses once per modulator period on clk.
`timescale 1ns/10ps
`include "shunt_adc_cfg.svh"

module shunt_sinc3_cic #(
  parameter int W  = `SHUNT_CIC_W,
  parameter int CW = `SHUNT_CNT_W
) (
  input  wire logic         clk,        // Main clock
  input  wire logic         arst_n,     // Async reset, active low
  input  wire logic         sample_en,  // One modulator period elapsed
  input  wire logic         bit_in,     // Modulator ones-density bit
  input  wire logic [3:0]   osr_log2,   // log2 of decimation ratio
  input  wire logic         restart,    // Clear filter state
  output logic      [W-1:0] data,       // Unsigned sum, 0 .. OSR^3
  output logic              data_valid  // One-cycle result strobe
);

  logic [W-1:0]  integ_ff [3];
  logic [W-1:0]  nxt_integ [3];
  logic [W-1:0]  comb_dly_ff [3];
  logic [W-1:0]  comb_out [4];
  logic [CW-1:0] count_ff;
  logic [CW:0]   osr_full;
  logic [CW-1:0] osr_m1;
  logic          decim;

  assign osr_full = (CW+1)'(1) << osr_log2;
  assign osr_m1   = CW'(osr_full - (CW+1)'(1));
  assign decim    = sample_en && (count_ff == osr_m1);

  // ============================================================
  // Integrators; wrap-around arithmetic is exact for the final sum
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_integ
      // Chained, not pipelined, so a cleared filter settles in exactly three outputs
      if (i == 0) begin : g_first
        assign nxt_integ[i] = integ_ff[i] + W'(bit_in);
      end else begin : g_next
        assign nxt_integ[i] = integ_ff[i] + nxt_integ[i-1];
      end
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          integ_ff[i] <= '0;
        end else if (restart) begin
          integ_ff[i] <= '0;
        end else if (sample_en) begin
          integ_ff[i] <= nxt_integ[i];
        end
      end
    end
  endgenerate

  // ============================================================
  // Decimation counter: one output per OSR modulator periods
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= '0;
    end else if (restart || decim) begin
      count_ff <= '0;
    end else if (sample_en) begin
      count_ff <= count_ff + CW'(1);
    end
  end

  // ============================================================
  // Combs at the output rate
  assign comb_out[0] = integ_ff[2];
  generate
    for (i = 0; i < 3; i++) begin : g_comb
      assign comb_out[i+1] = comb_out[i] - comb_dly_ff[i];
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          comb_dly_ff[i] <= '0;
        end else if (restart) begin
          comb_dly_ff[i] <= '0;
        end else if (decim) begin
          comb_dly_ff[i] <= comb_out[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data       <= '0;
      data_valid <= 1'b0;
    end else begin
      data_valid <= decim && !restart;
      if (decim) begin
        data <= comb_out[3];
      end
    end
  end

endmodule : shunt_sinc3_cic

/* sim/shunt_mod_model.sv */
// Behavioural modulator standing at the far side of the sample pin.
// Assumes mod_clk is the design's halved clock; mode picks the bit pattern.
`timescale 1ns/10ps

module shunt_mod_model (
  input  wire logic       clk,      // Main clock
  input  wire logic       mod_clk,  // Modulator clock from the design
  input  wire logic [1:0] mode,     // 0 zeros, 1 ones, else alternating
  output logic            bit_out   // Ones-density bit
);
  // ============================================================
  // One new bit per modulator period, changed away from the sampling edge
  initial bit_out = 1'b0;
  always @(negedge clk) begin
    if (mod_clk) begin
      case (mode)
        2'h0:    bit_out <= 1'b0;
        2'h1:    bit_out <= 1'b1;
        default: bit_out <= ~bit_out;
      endcase
    end
  end
endmodule : shunt_mod_model

/* sim/shunt_adc_sinc3_decimator_cal_tb.sv */
// Self-checking bench for the shunt converter back end.
// Assumes the modulator model above; inputs change on the falling edge.
`timescale 1ns/10ps

module shunt_adc_sinc3_decimator_cal_tb;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        mod_bit_in;
  logic [1:0]  mod_mode = 2'h2;
  logic [2:0]  ratio = 3'h0;
  logic [7:0]  off_hi = 8'h00;
  logic [15:0] off_lo = 16'h0000;
  logic [15:0] gain = 16'h0000;
  logic [1:0]  amp_sel = 2'h0;
  logic [1:0]  in_sel = 2'h0;
  logic        frame_start = 1'b0;
  logic        rd_frame = 1'b0;
  logic [23:0] rd_data = 24'h000000;
  logic        mod_clk_out;
  logic [1:0]  amp_gain_ctrl;
  logic [1:0]  input_select_ctrl;
  logic [23:0] result_code;
  logic        result_valid;
  logic [23:0] frame_word;
  int          failures = 0;
  int          check_count = 0;

  always #4 clk = ~clk;

  shunt_adc_sinc3_decimator_cal i_dut (
    .clk(clk), .arst_n(arst_n), .mod_bit_in(mod_bit_in),
    .shunt_decimation_ratio_sel(ratio), .shunt_offset_trim_upper(off_hi),
    .shunt_offset_trim_lower(off_lo), .shunt_gain_trim(gain),
    .shunt_amp_gain_sel(amp_sel), .shunt_input_select(in_sel),
    .frame_start(frame_start), .reg_read_frame(rd_frame), .reg_read_data(rd_data),
    .mod_clk_out(mod_clk_out), .amp_gain_ctrl(amp_gain_ctrl),
    .input_select_ctrl(input_select_ctrl), .result_code(result_code),
    .result_valid(result_valid), .frame_word(frame_word));

  shunt_mod_model i_mod (.clk(clk), .mod_clk(mod_clk_out), .mode(mod_mode),
    .bit_out(mod_bit_in));

  // ============================================================
  // Shared checking and waiting
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // Bounded so a silent filter cannot hang the run
  task automatic wait_result(output int gap);
    gap = 0;
    do begin
      @(negedge clk);
      gap++;
    end while (result_valid !== 1'b1 && gap < 70000);
    if (gap >= 70000) begin
      failures++;
      $display("unexpected result_valid expected 1 seen 0");
    end
  endtask : wait_result

  // Four results flush the sinc3 window after any change of pattern or trim
  task automatic cal_case(input logic [1:0] m, input logic [23:0] off,
                          input logic [15:0] g, input logic [23:0] exp);
    int gap;
    mod_mode = m;
    {off_hi, off_lo} = off;
    gain = g;
    repeat (4) wait_result(gap);
    check("result_code", result_code, exp);
    @(negedge clk);
    check("result_valid low", {23'h0, result_valid}, 24'h0);
  endtask : cal_case

  // ============================================================
  // Scenarios
  task automatic t_reset();
    arst_n = 1'b0;
    repeat (2) @(negedge clk);
    check("reset result", result_code, 24'h0);
    check("reset strobe", {23'h0, result_valid}, 24'h0);
    check("reset frame", frame_word, 24'h0);
    check("reset modclk", {23'h0, mod_clk_out}, 24'h0);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      check("mod_clk_out", {23'h0, mod_clk_out}, {23'h0, ~i[0]});
    end
  endtask : t_reset

  task automatic t_ratio();
    int gap;
    mod_mode = 2'h2;
    for (int c = 0; c < 5; c++) begin
      ratio = 3'(c);
      wait_result(gap);
      check("first kept", result_code, 24'h0);
      repeat (2) wait_result(gap);
      wait_result(gap);
      check("result spacing", 24'(gap), 24'(2 * (64 << c)));
      check("ratio result", result_code, 24'h0);
    end
    ratio = 3'h0;
  endtask : t_ratio

  task automatic t_trims();
    in_sel = 2'h2;
    cal_case(2'h2, 24'h000000, 16'h0000, 24'h000000);
    cal_case(2'h1, 24'h000000, 16'h0000, 24'h7FFFFF);
    cal_case(2'h0, 24'h000000, 16'h0000, 24'h800000);
    cal_case(2'h2, 24'h000010, 16'h0000, 24'hFFFFF0);
    cal_case(2'h2, 24'hFFFFF0, 16'h0000, 24'h000010);
    cal_case(2'h2, 24'h010000, 16'h0000, 24'hFF0000);
    cal_case(2'h2, 24'hFFFFF0, 16'h8000, 24'h000008);
    cal_case(2'h2, 24'hFFFFF0, 16'h7FFF, 24'h000018);
    cal_case(2'h2, 24'hFFFFF0, 16'hFFFF, 24'h000010);
    cal_case(2'h0, 24'h000000, 16'h8000, 24'hC00000);
    cal_case(2'h2, 24'hFFFFFD, 16'h8000, 24'h000002);
    cal_case(2'h2, 24'h000003, 16'h8000, 24'hFFFFFF);
    cal_case(2'h1, 24'hFFFFF0, 16'h0000, 24'h7FFFFF);
    cal_case(2'h0, 24'h000010, 16'h7FFF, 24'h800000);
  endtask : t_trims

  // Frames back to back: data frame, then register frame, then hold
  task automatic t_frame();
    cal_case(2'h2, 24'h000010, 16'h0000, 24'hFFFFF0);
    frame_start = 1'b1;
    rd_frame = 1'b0;
    @(negedge clk);
    check("frame data", frame_word, 24'hFFFFF0);
    rd_frame = 1'b1;
    rd_data = 24'hA5C3E1;
    @(negedge clk);
    check("frame reg", frame_word, 24'hA5C3E1);
    frame_start = 1'b0;
    rd_data = 24'h123456;
    @(negedge clk);
    check("frame hold", frame_word, 24'hA5C3E1);
    rd_frame = 1'b0;
  endtask : t_frame

  task automatic t_front();
    for (int i = 0; i < 4; i++) begin
      amp_sel = 2'(i + 1);
      in_sel = 2'(3 - i);
      #1;
      check("amp before", {22'h0, amp_gain_ctrl}, 24'(i));
      @(negedge clk);
      check("amp gain", {22'h0, amp_gain_ctrl}, 24'((i + 1) % 4));
      check("input sel", {22'h0, input_select_ctrl}, 24'(3 - i));
    end
  endtask : t_front

  // ============================================================
  // Main sequence and watchdog
  initial begin
    t_reset();
    t_front();
    t_ratio();
    t_trims();
    t_frame();
    {off_hi, off_lo} = 24'h0;
    gain = 16'h0;
    @(negedge clk);
    t_reset();
    // Trims are re-presented by the host after reset
    cal_case(2'h2, 24'hFFFFF0, 16'h8000, 24'h000008);
    conclude();
  end

  initial begin
    #600000;
    failures++;
    $display("unexpected watchdog expected finish seen timeout");
    conclude();
  end
endmodule : shunt_adc_sinc3_decimator_cal_tb
